// *** ccg_pkg.sv ***
// ccg_pkg: constants and types for the codec clock and reset generator
package ccg_pkg;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    localparam int unsigned RST_MCLK_CYCLES = 8;
    localparam logic [3:0]  RST_CNT_LAST    = 4'(RST_MCLK_CYCLES - 1);
    localparam logic [3:0]  RST_CNT_INIT    = 4'h0;

    // ----------------------------------------------------------------
    // synchronous master clock ratios, in master clocks per sample
    // ----------------------------------------------------------------
    localparam logic [9:0]  RATIO_256_VAL   = 10'h100;
    localparam logic [9:0]  RATIO_384_VAL   = 10'h180;
    localparam logic [9:0]  RATIO_512_VAL   = 10'h200;

    // ----------------------------------------------------------------
    // pll divider layout: step = integer * 2048 + fraction
    // ----------------------------------------------------------------
    localparam int unsigned INT_DIV_W       = 5;
    localparam int unsigned FRAC_DIV_W      = 11;
    localparam int unsigned STEP_W          = INT_DIV_W + FRAC_DIV_W;
    // one sample = 4096 pll cycles, each split into 2048 parts
    localparam int unsigned PHASE_W         = 23;
    localparam logic [PHASE_W-1:0] PHASE_INIT = 23'h0;

    typedef enum logic [1:0] {
        RATIO_256,
        RATIO_384,
        RATIO_512,
        RATIO_BAD
    } ccg_ratio_t;

    typedef enum logic [2:0] {
        FS_8K,
        FS_11K025,
        FS_16K,
        FS_22K5,
        FS_32K,
        FS_44K1,
        FS_48K,
        FS_96K
    } ccg_fs_t;

    typedef struct packed {
        logic                  use_pll;
        ccg_ratio_t            ratio;
        ccg_fs_t               fs;
        logic                  refclk_halve;
        logic [INT_DIV_W-1:0]  pll_integer_divider;
        logic [FRAC_DIV_W-1:0] pll_fraction_divider;
    } ccg_cfg_t;

endpackage

// *** ccg_core.sv ***
// ccg_core: power-up reset release and sample clock derivation
`timescale 1ns/1ps
module ccg_core (
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    input  wire logic             i_master_clock_in,
    input  wire ccg_pkg::ccg_cfg_t i_cfg,
    output logic                  o_int_rst_n,
    output logic                  o_ctrl_ready,
    output logic                  o_pll_run,
    output logic                  o_fs_tick,
    output logic                  o_cfg_err
);

    // ----------------------------------------------------------------
    // master clock edge and reference path
    // ----------------------------------------------------------------
    logic                          mclk_prev_reg;
    logic [3:0]                    rst_cnt_reg;
    logic [3:0]                    rst_cnt_next;
    logic                          ready_reg;
    logic                          half_phase_reg;
    logic [9:0]                    sync_cnt_reg;
    logic [9:0]                    sync_cnt_next;
    logic [ccg_pkg::PHASE_W-1:0]   phase_reg;
    logic [ccg_pkg::PHASE_W-1:0]   phase_next;
    logic                          fs_tick_reg;
    logic                          pll_run_reg;
    logic                          cfg_err_reg;

    wire logic                     mclk_rise;
    wire logic                     ref_edge;
    wire logic [9:0]               ratio_val;
    wire logic                     sync_wrap;
    wire logic [ccg_pkg::STEP_W-1:0] pll_step;
    wire logic [ccg_pkg::PHASE_W:0]  phase_sum;
    wire logic                     pll_carry;
    wire logic                     ratio_bad;
    wire logic                     fs_tick_next;

    // inputs are synchronous, so a plain previous-value compare suffices
    assign mclk_rise = i_master_clock_in & ~mclk_prev_reg;

    // halving drops every other master edge from the reference
    assign ref_edge  = mclk_rise & (~i_cfg.refclk_halve | half_phase_reg);

    // ----------------------------------------------------------------
    // reset release counter
    // ----------------------------------------------------------------
    assign rst_cnt_next = (mclk_rise && !ready_reg) ? rst_cnt_reg + 4'h1 : rst_cnt_reg;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mclk_prev_reg  <= 1'b0;
            rst_cnt_reg    <= ccg_pkg::RST_CNT_INIT;
            ready_reg      <= 1'b0;
        end else begin
            mclk_prev_reg  <= i_master_clock_in;
            rst_cnt_reg    <= rst_cnt_next;
            // released on the eighth master edge after power-up
            if (mclk_rise && rst_cnt_reg == ccg_pkg::RST_CNT_LAST) begin
                ready_reg  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // synchronous mode: divide master clock by the ratio
    // ----------------------------------------------------------------
    assign ratio_val = (i_cfg.ratio == ccg_pkg::RATIO_384) ? ccg_pkg::RATIO_384_VAL :
                       (i_cfg.ratio == ccg_pkg::RATIO_512) ? ccg_pkg::RATIO_512_VAL :
                                                             ccg_pkg::RATIO_256_VAL;
    assign sync_wrap = mclk_rise && (sync_cnt_reg >= ratio_val - 10'h001);
    assign sync_cnt_next = (!ready_reg || i_cfg.use_pll) ? 10'h000 :
                           sync_wrap ? 10'h000 :
                           mclk_rise ? sync_cnt_reg + 10'h001 : sync_cnt_reg;

    // 96 kHz only runs at 256; the unused ratio code is also refused
    assign ratio_bad = !i_cfg.use_pll &&
                       ((i_cfg.ratio == ccg_pkg::RATIO_BAD) ||
                        (i_cfg.fs == ccg_pkg::FS_96K && i_cfg.ratio != ccg_pkg::RATIO_256));

    // ----------------------------------------------------------------
    // pll mode: fractional phase accumulator on reference edges
    // ----------------------------------------------------------------
    // each reference edge yields step/2048 pll cycles; a sample is 4096 of them
    assign pll_step  = {i_cfg.pll_integer_divider, i_cfg.pll_fraction_divider};
    assign phase_sum = {1'b0, phase_reg} + (ccg_pkg::PHASE_W + 1)'(pll_step);
    assign pll_carry = ref_edge & phase_sum[ccg_pkg::PHASE_W];
    // accumulator held at zero in synchronous mode: the pll does no work there
    assign phase_next = (!ready_reg || !i_cfg.use_pll) ? ccg_pkg::PHASE_INIT :
                        ref_edge ? phase_sum[ccg_pkg::PHASE_W-1:0] : phase_reg;

    assign fs_tick_next = ready_reg && (i_cfg.use_pll ? pll_carry : sync_wrap);

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            half_phase_reg <= 1'b0;
            sync_cnt_reg   <= 10'h000;
            phase_reg      <= ccg_pkg::PHASE_INIT;
            fs_tick_reg    <= 1'b0;
            pll_run_reg    <= 1'b0;
            cfg_err_reg    <= 1'b0;
        end else begin
            if (mclk_rise) begin
                half_phase_reg <= ~half_phase_reg;
            end
            sync_cnt_reg   <= sync_cnt_next;
            phase_reg      <= phase_next;
            fs_tick_reg    <= fs_tick_next;
            pll_run_reg    <= ready_reg & i_cfg.use_pll;
            cfg_err_reg    <= ready_reg & ratio_bad;
        end
    end

    assign o_int_rst_n  = ready_reg;
    assign o_ctrl_ready = ready_reg;
    assign o_pll_run    = pll_run_reg;
    assign o_fs_tick    = fs_tick_reg;
    assign o_cfg_err    = cfg_err_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [9:0] gap_cnt_reg;
    logic       gap_valid_reg;

    // master edges since the last sample tick, for period checks
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gap_cnt_reg   <= 10'h000;
            gap_valid_reg <= 1'b0;
        end else begin
            if (fs_tick_next) begin
                gap_cnt_reg   <= 10'h000;
                gap_valid_reg <= 1'b1;
            end else if (mclk_rise) begin
                gap_cnt_reg   <= gap_cnt_reg + 10'h001;
            end
            if (i_cfg.use_pll || $changed(i_cfg.ratio)) begin
                gap_valid_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    a_rst_held_early: assert property (rst_cnt_reg < 4'h7 |-> !o_int_rst_n)
        else $error("internal reset released before eight master edges");
    a_rst_release_edge: assert property ($rose(o_ctrl_ready) |-> $past(mclk_rise)
                                         && $past(rst_cnt_reg) == 4'h7)
        else $error("reset release not on eighth master edge");
    a_no_tick_reset: assert property (!o_ctrl_ready |=> !o_fs_tick)
        else $error("sample tick while internal reset held");
    a_sync_period: assert property (fs_tick_next && gap_valid_reg && !i_cfg.use_pll
                                    && $stable(i_cfg.ratio)
                                    |-> gap_cnt_reg + 10'h001 == ratio_val)
        else $error("synchronous sample period differs from ratio");
    a_err_96k: assert property (o_ctrl_ready && !i_cfg.use_pll && i_cfg.fs == ccg_pkg::FS_96K
                                && i_cfg.ratio == ccg_pkg::RATIO_512 |=> o_cfg_err)
        else $error("96 kHz with ratio 512 not flagged");
    a_pll_off_sync: assert property (!i_cfg.use_pll ##1 !i_cfg.use_pll
                                     |-> !o_pll_run && phase_reg == 23'h0)
        else $error("pll active in synchronous mode");
    a_pll_tick_ref: assert property (o_fs_tick && $past(i_cfg.use_pll)
                                     |-> $past(ref_edge) && $past(phase_sum[23]))
        else $error("pll sample tick without accumulator carry");
    a_halve_skip: assert property (i_cfg.refclk_halve && mclk_rise && !half_phase_reg
                                   |-> !ref_edge)
        else $error("halved reference passed a skipped edge");
    a_frac_step: assert property (o_pll_run && ref_edge && i_cfg.use_pll && !pll_carry
                                  |=> phase_reg > $past(phase_reg) || $past(pll_step) == 16'h0)
        else $error("pll phase did not advance by the divider step");

    // release is one-way: only the power-up reset may pull it back
    a_rst_stays: assert property (o_ctrl_ready |=> o_ctrl_ready)
        else $error("internal reset asserted again without power-up reset");

    // both views of the release come from one flop and never split
    a_rst_views: assert property (o_int_rst_n == o_ctrl_ready)
        else $error("internal reset and control ready disagree");

    a_pll_follow: assert property (o_pll_run == ($past(o_ctrl_ready) && $past(i_cfg.use_pll)))
        else $error("pll run does not follow mode and release");

    // error flag belongs to synchronous mode only
    a_err_sync_only: assert property (o_cfg_err |-> !$past(i_cfg.use_pll))
        else $error("configuration error flagged in pll mode");

    // master edges are at least two clocks apart, so a tick never repeats at once
    a_tick_single: assert property (o_fs_tick |=> !o_fs_tick)
        else $error("sample tick longer than one cycle");

    // largest ratio bounds the divider, also after a ratio change
    a_sync_range: assert property (sync_cnt_reg < ccg_pkg::RATIO_512_VAL)
        else $error("synchronous divider ran past the largest ratio");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    c_ready_rise: cover property ($rose(o_ctrl_ready));
    c_sync_tick:  cover property (o_fs_tick && !o_pll_run);
    c_pll_tick:   cover property (o_fs_tick && o_pll_run);
    c_cfg_err:    cover property ($rose(o_cfg_err));
    c_halve_tick: cover property (o_fs_tick && o_pll_run && i_cfg.refclk_halve);

endmodule // ccg_core

// *** ccg_mclk_src.sv ***
// ccg_mclk_src: free-running master clock source for the clock generator bench
`timescale 1ns/1ps
module ccg_mclk_src (
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_half_cycles,
    output logic            o_master_clock_in
);
    logic [3:0] cnt_reg;

    initial begin
        cnt_reg           = 4'h0;
        o_master_clock_in = 1'b0;
    end

    // runs free, also through reset: the core counts its edges from release
    always @(posedge i_clk_sys) begin
        if (cnt_reg + 4'h1 >= i_half_cycles) begin
            cnt_reg           <= 4'h0;
            o_master_clock_in <= ~o_master_clock_in;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule // ccg_mclk_src

// *** tb_top.sv ***
// tb_top: self-checking bench for the codec clock and reset generator
`timescale 1ns/1ps
module tb_top;
    logic              i_clk_sys;
    logic              i_sys_rst;
    logic              mclk;
    logic              mprev;
    logic [3:0]        half_cyc;
    ccg_pkg::ccg_cfg_t cfg;
    logic              rst_n, ready, pll_run, tick, cfg_err;
    int                fail_count, compares, rise_cnt;

    ccg_mclk_src src (.i_clk_sys(i_clk_sys), .i_half_cycles(half_cyc), .o_master_clock_in(mclk));
    ccg_core uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_master_clock_in(mclk),
        .i_cfg(cfg), .o_int_rst_n(rst_n), .o_ctrl_ready(ready), .o_pll_run(pll_run),
        .o_fs_tick(tick), .o_cfg_err(cfg_err));

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // reference rise count, sampled on the same edge as the core
    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mprev    <= 1'b0;
            rise_cnt <= 0;
        end else begin
            mprev <= mclk;
            if (mclk && !mprev) begin
                rise_cnt <= rise_cnt + 1;
            end
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_num(input string name, input int exp, input int got);
        compares++;
        if (got != exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic set_cfg(input logic pll, input ccg_pkg::ccg_ratio_t r,
                           input ccg_pkg::ccg_fs_t fs, input logic hv, input logic [10:0] fd);
        @(posedge i_clk_sys);
        cfg <= '{pll, r, fs, hv, 5'h10, fd};
        repeat (3) @(negedge i_clk_sys);
    endtask

    task automatic wait_tick();
        int n;
        n = 0;
        @(negedge i_clk_sys);
        while (tick !== 1'b1 && n < 3000) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk_bit("fs_tick_seen", 1'b1, tick);
    endtask

    // first two intervals after a change are skipped: counters are not restarted
    task automatic interval(output int n);
        int r0;
        wait_tick();
        wait_tick();
        r0 = rise_cnt;
        wait_tick();
        n = rise_cnt - r0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        repeat (80) begin
            @(negedge i_clk_sys);
            chk_bit("ctrl_ready", rise_cnt >= 8, ready);
            chk_bit("int_rst_n", rise_cnt >= 8, rst_n);
            if (rise_cnt < 8) begin
                chk_bit("pll_run_early", 1'b0, pll_run);
                chk_bit("tick_early", 1'b0, tick);
            end
        end
        @(posedge i_clk_sys);
        half_cyc <= 4'h1;
    endtask

    task automatic t_sync();
        ccg_pkg::ccg_ratio_t rs[3] = '{ccg_pkg::RATIO_256, ccg_pkg::RATIO_384, ccg_pkg::RATIO_512};
        logic [9:0] ev[3] = '{ccg_pkg::RATIO_256_VAL, ccg_pkg::RATIO_384_VAL, ccg_pkg::RATIO_512_VAL};
        int n;
        foreach (rs[i]) begin
            set_cfg(1'b0, rs[i], ccg_pkg::FS_48K, 1'b0, 11'h000);
            interval(n);
            chk_num("sync_interval", int'(ev[i]), n);
            chk_bit("pll_run_sync", 1'b0, pll_run);
            chk_bit("cfg_err_sync", 1'b0, cfg_err);
        end
    endtask

    task automatic t_err();
        ccg_pkg::ccg_ratio_t rs[5] = '{ccg_pkg::RATIO_256, ccg_pkg::RATIO_384, ccg_pkg::RATIO_512,
                                       ccg_pkg::RATIO_BAD, ccg_pkg::RATIO_384};
        logic ps[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        logic ex[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        foreach (rs[i]) begin
            set_cfg(ps[i], rs[i], (i == 3) ? ccg_pkg::FS_48K : ccg_pkg::FS_96K, 1'b0, 11'h000);
            chk_bit("cfg_err", ex[i], cfg_err);
            chk_bit("pll_run", ps[i], pll_run);
        end
    endtask

    task automatic t_pll();
        logic [10:0] fv[3] = '{11'h000, 11'h000, 11'h312};
        logic hv[3] = '{1'b0, 1'b1, 1'b0};
        int step, m, lo, hi, n;
        foreach (fv[i]) begin
            set_cfg(1'b1, ccg_pkg::RATIO_256, ccg_pkg::FS_48K, hv[i], fv[i]);
            step = 16 * 2048 + int'(fv[i]);
            m = hv[i] ? 2 : 1;
            lo = (32'h800000 / step) * m;
            hi = ((32'h800000 + step - 1) / step) * m;
            interval(n);
            chk_num("pll_interval_ok", 1, int'(n >= lo && n <= hi));
            chk_bit("pll_run_pll", 1'b1, pll_run);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        compares   = 0;
        i_sys_rst  = 1'b1;
        half_cyc   = 4'h3;
        cfg        = '{1'b1, ccg_pkg::RATIO_256, ccg_pkg::FS_48K, 1'b0, 5'h10, 11'h000};
        t_reset();
        t_sync();
        t_err();
        t_pll();
        report_and_stop();
    end

    // about 13k cycles expected; 50k cycles before giving up
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule // tb_top
